/* src/half_bridge_fault_manager.sv */
// Summary of operation
// - fault indicator low while any fault flagged
// - overcurrent starts filter, no flags yet
// - filter expiry latches switch off, sets flag
// - latched overcurrent or open-load sets load error
// - switch stays off while overcurrent flag set
// - enable bits untouched across overcurrent event
// - prewarning latches bit 1, outputs unchanged
// - thermal shutdown latches bit 2, outputs off
// - undervoltage latches bit 5, auto recovery
// - overvoltage latches bit 4, auto recovery
// - enable low resets flags, filter counters and status, drives off
`timescale 1ns/1ns
module half_bridge_fault_manager (
  // clock, reset, clock enable
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // device enable pin (low means sleep)
  input wire logic i_enable,
  // half-bridge enable control bits from the control registers
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_high_side_enable,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_low_side_enable,
  // analog comparator conditions (asynchronous)
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_hs_overcurrent,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_ls_overcurrent,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_hs_openload,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_ls_openload,
  input wire logic i_temp_prewarn,
  input wire logic i_temp_shutdown,
  input wire logic i_supply_undervolt,
  input wire logic i_supply_overvolt,
  // clear strobes from the serial register access, one cycle each
  input wire logic [7:0] i_global_clear,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_hs_oc_clear,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_ls_oc_clear,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_hs_ol_clear,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] i_ls_ol_clear,
  // status registers
  output logic [7:0] o_global_fault_status,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_high_side_overcurrent_flag,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_low_side_overcurrent_flag,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_high_side_openload_flag,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_low_side_openload_flag,
  // switch gate drive, current limit and fault pin
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_hs_drive,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_ls_drive,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_hs_current_limit,
  output logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_ls_current_limit,
  output logic o_fault_indicator_low
);
  import hb_fault_pkg::*;

  localparam int unsigned N = NUM_BRIDGES;
  localparam int unsigned NA = 4 * N + 4;

  // all asynchronous conditions in one vector
  logic [NA-1:0] async_in;
  logic [NA-1:0] sync1_r;
  logic [NA-1:0] sync2_r;
  logic en_sync1_r;
  logic en_sync2_r;
  logic soft_rst;
  logic [N-1:0] hs_oc_c;
  logic [N-1:0] ls_oc_c;
  logic [N-1:0] hs_ol_c;
  logic [N-1:0] ls_ol_c;
  logic prewarn_c;
  logic thermal_c;
  logic uv_c;
  logic ov_c;
  logic [7:0] gstat_r;
  logic [7:0] gstat_nxt;
  logic [N-1:0] hs_oc_r;
  logic [N-1:0] ls_oc_r;
  logic [N-1:0] hs_ol_r;
  logic [N-1:0] ls_ol_r;
  logic [N-1:0] hs_expire;
  logic [N-1:0] ls_expire;
  logic [N-1:0] hs_filt;
  logic [N-1:0] ls_filt;
  logic global_off;

  assign async_in = {i_supply_overvolt, i_supply_undervolt, i_temp_shutdown, i_temp_prewarn,
                     i_ls_openload, i_hs_openload, i_ls_overcurrent, i_hs_overcurrent};
  assign hs_oc_c = sync2_r[N-1:0];
  assign ls_oc_c = sync2_r[2*N-1:N];
  assign hs_ol_c = sync2_r[3*N-1:2*N];
  assign ls_ol_c = sync2_r[4*N-1:3*N];
  assign prewarn_c = sync2_r[4*N];
  assign thermal_c = sync2_r[4*N+1];
  assign uv_c = sync2_r[4*N+2];
  assign ov_c = sync2_r[4*N+3];

  // two-stage synchronisers for pins and comparators
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
      en_sync1_r <= 1'b0;
      en_sync2_r <= 1'b0;
    end else if (i_ce) begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      en_sync1_r <= i_enable;
      en_sync2_r <= en_sync1_r;
    end
  end

  assign soft_rst = ~en_sync2_r;

  // per-channel overcurrent filter and latched flags
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      logic [OC_CNT_W-1:0] hs_cnt_r;
      logic [OC_CNT_W-1:0] ls_cnt_r;
      always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          hs_cnt_r <= OC_CNT_RST;
          ls_cnt_r <= OC_CNT_RST;
        end else if (i_ce) begin
          // counter restarts whenever the condition is gone or switch latched
          if (soft_rst || !hs_oc_c[g] || hs_oc_r[g]) begin
            hs_cnt_r <= OC_CNT_RST;
          end else if (hs_cnt_r != OC_FILTER_CYCLES) begin
            hs_cnt_r <= hs_cnt_r + 1'b1;
          end
          if (soft_rst || !ls_oc_c[g] || ls_oc_r[g]) begin
            ls_cnt_r <= OC_CNT_RST;
          end else if (ls_cnt_r != OC_FILTER_CYCLES) begin
            ls_cnt_r <= ls_cnt_r + 1'b1;
          end
        end
      end
      assign hs_expire[g] = hs_oc_c[g] && !hs_oc_r[g] && (hs_cnt_r == OC_FILTER_CYCLES - 1'b1);
      assign ls_expire[g] = ls_oc_c[g] && !ls_oc_r[g] && (ls_cnt_r == OC_FILTER_CYCLES - 1'b1);
      // filtering phase: current limited, nothing flagged yet
      assign hs_filt[g] = hs_oc_c[g] && !hs_oc_r[g];
      assign ls_filt[g] = ls_oc_c[g] && !ls_oc_r[g];

      always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          hs_oc_r[g] <= 1'b0;
          ls_oc_r[g] <= 1'b0;
          hs_ol_r[g] <= 1'b0;
          ls_ol_r[g] <= 1'b0;
        end else if (i_ce) begin
          if (soft_rst) begin
            hs_oc_r[g] <= 1'b0;
            ls_oc_r[g] <= 1'b0;
            hs_ol_r[g] <= 1'b0;
            ls_ol_r[g] <= 1'b0;
          end else begin
            hs_oc_r[g] <= hs_expire[g] | (hs_oc_r[g] & ~i_hs_oc_clear[g]);
            ls_oc_r[g] <= ls_expire[g] | (ls_oc_r[g] & ~i_ls_oc_clear[g]);
            // open load only counts on an activated switch
            hs_ol_r[g] <= (hs_ol_c[g] & i_high_side_enable[g])
                          | (hs_ol_r[g] & ~i_hs_ol_clear[g]);
            ls_ol_r[g] <= (ls_ol_c[g] & i_low_side_enable[g])
                          | (ls_ol_r[g] & ~i_ls_ol_clear[g]);
          end
        end
      end
    end
  endgenerate

  // global status next value, conditions re-set a cleared bit
  always_comb begin
    gstat_nxt = gstat_r & ~i_global_clear;
    if ((|hs_expire) || (|ls_expire) || (|(hs_ol_c & i_high_side_enable))
        || (|(ls_ol_c & i_low_side_enable))) begin
      gstat_nxt[LOAD_ERR_BIT] = 1'b1;
    end
    if (prewarn_c) begin
      gstat_nxt[PREWARN_BIT] = 1'b1;
    end
    if (thermal_c) begin
      gstat_nxt[THERMAL_OFF_BIT] = 1'b1;
    end
    if (uv_c) begin
      gstat_nxt[UV_BIT] = 1'b1;
    end
    if (ov_c) begin
      gstat_nxt[OV_BIT] = 1'b1;
    end
    // unused bits read zero
    gstat_nxt[0] = 1'b0;
    gstat_nxt[3] = 1'b0;
    gstat_nxt[7] = 1'b0;
  end

  // global status register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      gstat_r <= GLOBAL_STATUS_RST;
    end else if (i_ce) begin
      if (soft_rst) begin
        gstat_r <= GLOBAL_STATUS_RST;
      end else begin
        gstat_r <= gstat_nxt;
      end
    end
  end

  assign global_off = soft_rst | gstat_r[THERMAL_OFF_BIT] | uv_c | ov_c;

  // output stage drive, registered
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_hs_drive <= CHAN_FLAGS_RST;
      o_ls_drive <= CHAN_FLAGS_RST;
      o_hs_current_limit <= CHAN_FLAGS_RST;
      o_ls_current_limit <= CHAN_FLAGS_RST;
    end else if (i_ce) begin
      o_hs_drive <= global_off ? CHAN_FLAGS_RST
                    : (i_high_side_enable & ~hs_oc_r & ~hs_expire);
      o_ls_drive <= global_off ? CHAN_FLAGS_RST
                    : (i_low_side_enable & ~ls_oc_r & ~ls_expire);
      o_hs_current_limit <= hs_filt & ~hs_expire;
      o_ls_current_limit <= ls_filt & ~ls_expire;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_fault_indicator_low <= 1'b1;
    end else if (i_ce) begin
      o_fault_indicator_low <= ~((|gstat_r) | (|hs_oc_r) | (|ls_oc_r) | (|hs_ol_r)
                                 | (|ls_ol_r) | prewarn_c | thermal_c | uv_c | ov_c);
    end
  end

  assign o_global_fault_status = gstat_r;
  assign o_high_side_overcurrent_flag = hs_oc_r;
  assign o_low_side_overcurrent_flag = ls_oc_r;
  assign o_high_side_openload_flag = hs_ol_r;
  assign o_low_side_openload_flag = ls_ol_r;
endmodule // half_bridge_fault_manager

/* src/hb_fault_pkg.sv */
package hb_fault_pkg;
  // number of half-bridges supervised
  localparam int unsigned NUM_BRIDGES = 8;
  // global fault status bit positions
  localparam int unsigned PREWARN_BIT = 1;
  localparam int unsigned THERMAL_OFF_BIT = 2;
  localparam int unsigned OV_BIT = 4;
  localparam int unsigned UV_BIT = 5;
  localparam int unsigned LOAD_ERR_BIT = 6;
  // reset values
  localparam logic [7:0] GLOBAL_STATUS_RST = 8'h00;
  localparam logic [7:0] CHAN_FLAGS_RST = 8'h00;
  // overcurrent filter time in ns and its cycle count at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OC_FILTER_TIME_NS = 100;
  localparam int unsigned OC_FILTER_CYCLES_I =
    (OC_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OC_CNT_W = 8;
  localparam logic [OC_CNT_W-1:0] OC_FILTER_CYCLES = OC_CNT_W'(OC_FILTER_CYCLES_I);
  localparam logic [OC_CNT_W-1:0] OC_CNT_RST = 8'h00;
endpackage

/* verification/hb_mcu_model.sv */
`timescale 1ns/1ns
module hb_mcu_model (
  // clock
  input wire logic i_mclk,
  // clear strobes toward the block
  output logic [7:0] o_gclr,
  output logic [7:0] o_cclr
);
  // no clear pending at start
  initial begin
    o_gclr = 8'h00;
    o_cclr = 8'h00;
  end
  // clear reactivates switch
  // one-cycle clear pulse, then released
  task automatic clear(input logic [7:0] g, input logic [7:0] c);
    @(posedge i_mclk);
    o_gclr <= g;
    o_cclr <= c;
    @(posedge i_mclk);
    o_gclr <= 8'h00;
    o_cclr <= 8'h00;
  endtask
endmodule // hb_mcu_model

/* verification/hb_fault_props.sv */
`timescale 1ns/1ns
module hb_fault_props (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // enable and raw conditions
  input wire logic i_enable,
  input wire logic i_temp_prewarn,
  input wire logic i_supply_undervolt,
  // observed outputs
  input wire logic [7:0] o_global_fault_status,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_high_side_overcurrent_flag,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_hs_drive,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_ls_drive,
  input wire logic [hb_fault_pkg::NUM_BRIDGES-1:0] o_hs_current_limit,
  input wire logic o_fault_indicator_low
);
  import hb_fault_pkg::*;
  // sleep clears flags, filter counters and status, so checks pause there
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset || !i_enable);
  hs_oc_off_a: assert property ((o_hs_drive & o_high_side_overcurrent_flag) == 8'h00)
    else $error("switch driven with overcurrent flag set");
  lim_flag_a: assert property (
    (o_hs_current_limit & o_high_side_overcurrent_flag) == 8'h00)
    else $error("flag set during filter");
  oc_filter_a: assert property ($rose(|o_high_side_overcurrent_flag) |->
    $past(|o_hs_current_limit, 9) && !$past(|o_hs_current_limit, 10))
    else $error("overcurrent flag not at filter expiry");
  load_err_a: assert property (
    $rose(|o_high_side_overcurrent_flag) |-> o_global_fault_status[LOAD_ERR_BIT])
    else $error("load error bit missing");
  prewarn_set_a: assert property (i_temp_prewarn [*4] |-> o_global_fault_status[1])
    else $error("prewarning bit missing");
  uv_off_a: assert property (
    i_supply_undervolt [*5] |-> (o_hs_drive | o_ls_drive) == 8'h00)
    else $error("drive during undervoltage");
  thermal_hold_a: assert property (
    o_global_fault_status[THERMAL_OFF_BIT] |=> (o_hs_drive | o_ls_drive) == 8'h00)
    else $error("drive during thermal shutdown");
  ind_low_a: assert property (|o_global_fault_status |=> !o_fault_indicator_low)
    else $error("indicator high with fault");
endmodule // hb_fault_props
bind half_bridge_fault_manager hb_fault_props u_props (
  .i_mclk, .i_reset, .i_enable, .i_temp_prewarn, .i_supply_undervolt,
  .o_global_fault_status, .o_high_side_overcurrent_flag, .o_hs_drive,
  .o_ls_drive, .o_hs_current_limit, .o_fault_indicator_low
);

/* verification/tb_half_bridge_fault_manager.sv */
`timescale 1ns/1ns
module tb_half_bridge_fault_manager;
  import hb_fault_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_enable = 1'b0;
  logic [7:0] hs_en = 8'h00;
  logic [7:0] ls_en = 8'h00;
  logic [7:0] hs_oc = 8'h00;
  // low-side overcurrent and open-load conditions
  logic [7:0] ls_oc = 8'h00;
  logic [7:0] ol_hs = 8'h00;
  logic [7:0] ol_ls = 8'h00;
  logic [3:0] cond = 4'h0;
  logic [7:0] gclr, cclr, gst, hs_f, hs_d, ls_d;
  logic ind;
  // remaining flags and current limits
  logic [7:0] ls_f, hs_olf, ls_olf, hs_lim, ls_lim;
  // expected notes and the observed outputs in the same layout
  logic [72:0] exp_q[$];
  logic [72:0] got;
  logic [31:0] seed = 32'h0000000B;
  int unsigned gbit[4] = '{PREWARN_BIT, THERMAL_OFF_BIT, UV_BIT, OV_BIT};
  int mismatches = 0;
  int checks_done = 0;
  half_bridge_fault_manager u_dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1), .i_enable(i_enable),
    .i_high_side_enable(hs_en), .i_low_side_enable(ls_en),
    .i_hs_overcurrent(hs_oc), .i_ls_overcurrent(ls_oc),
    .i_hs_openload(ol_hs), .i_ls_openload(ol_ls),
    .i_temp_prewarn(cond[0]), .i_temp_shutdown(cond[1]),
    .i_supply_undervolt(cond[2]), .i_supply_overvolt(cond[3]),
    .i_global_clear(gclr), .i_hs_oc_clear(cclr), .i_ls_oc_clear(cclr),
    .i_hs_ol_clear(cclr), .i_ls_ol_clear(cclr),
    .o_global_fault_status(gst), .o_high_side_overcurrent_flag(hs_f),
    .o_low_side_overcurrent_flag(ls_f), .o_high_side_openload_flag(hs_olf),
    .o_low_side_openload_flag(ls_olf), .o_hs_drive(hs_d), .o_ls_drive(ls_d),
    .o_hs_current_limit(hs_lim), .o_ls_current_limit(ls_lim), .o_fault_indicator_low(ind)
  );
  hb_mcu_model u_mcu (.i_mclk(i_mclk), .o_gclr(gclr), .o_cclr(cclr));
  // every output in one word for the monitor
  assign got = {ls_f, hs_olf, ls_olf, hs_lim, ls_lim, ind, gst, hs_f, hs_d, ls_d};
  // xorshift source for enables and channel choice
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // note an expectation for the monitor
  // x holds low-side flags, open-load flags and limits, zero unless given
  task automatic want(input logic [32:0] e, input logic [39:0] x = 40'h0);
    @(posedge i_mclk);
    exp_q.push_back({x, e});
  endtask
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  // monitor: oldest note against settled outputs
  always @(negedge i_mclk) begin
    if (exp_q.size() > 0) begin
      checks_done++;
      if (got !== exp_q[0]) begin
        mismatches++;
        $display("ERROR %0t: got %h want %h", $time, got, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  // watchdog against a hang
  initial begin
    step(3000);
    mismatches++;
    conclude();
  end
  initial begin
    logic [7:0] m;
    logic [7:0] s;
    step(6);
    i_reset <= 1'b0;
    i_enable <= 1'b1;
    hs_en <= 8'(xs());
    ls_en <= 8'(xs());
    step(4);
    want({1'b1, 8'h00, 8'h00, hs_en, ls_en});
    // overcurrent on a random high-side switch
    m = 8'h01 << (xs() % 8);
    hs_en <= hs_en | m;
    hs_oc <= m;
    step(6);
    want({1'b1, 8'h00, 8'h00, hs_en, ls_en}, {24'h0, m, 8'h00});
    step(6);
    want({1'b0, 8'h40, m, hs_en & ~m, ls_en});
    u_mcu.clear(8'h00, m);
    step(2);
    // switch retries under limit while the condition is still there
    want({1'b0, 8'h40, 8'h00, hs_en, ls_en}, {24'h0, m, 8'h00});
    step(7);
    want({1'b0, 8'h40, m, hs_en & ~m, ls_en});
    hs_oc <= 8'h00;
    step(3);
    u_mcu.clear(8'h00, m);
    step(2);
    want({1'b0, 8'h40, 8'h00, hs_en, ls_en});
    u_mcu.clear(8'h40, 8'h00);
    step(2);
    want({1'b1, 8'h00, 8'h00, hs_en, ls_en});
    // each global condition: set, drop, clear
    for (int k = 0; k < 4; k++) begin
      s = 8'h01 << gbit[k];
      cond[k] <= 1'b1;
      step(5);
      want({1'b0, s, 8'h00, (k == 0) ? hs_en : 8'h00, (k == 0) ? ls_en : 8'h00});
      cond[k] <= 1'b0;
      step(5);
      want({1'b0, s, 8'h00, (k == 1) ? 8'h00 : hs_en, (k == 1) ? 8'h00 : ls_en});
      u_mcu.clear(s, 8'h00);
      step(3);
      want({1'b1, 8'h00, 8'h00, hs_en, ls_en});
    end
    // sleep with a latched fault
    cond[3] <= 1'b1;
    step(5);
    cond[3] <= 1'b0;
    i_enable <= 1'b0;
    step(6);
    want({1'b1, 8'h00, 8'h00, 8'h00, 8'h00});
    i_enable <= 1'b1;
    step(5);
    want({1'b1, 8'h00, 8'h00, hs_en, ls_en});
    // low-side overcurrent plus open load on every switch
    m = 8'h01 << (xs() % 8);
    ls_en <= ls_en | m;
    ls_oc <= m;
    ol_hs <= 8'hFF;
    ol_ls <= 8'hFF;
    step(4);
    want({1'b0, 8'h40, 8'h00, hs_en, ls_en}, {8'h00, hs_en, ls_en, 8'h00, m});
    step(7);
    want({1'b0, 8'h40, 8'h00, hs_en, ls_en & ~m}, {m, hs_en, ls_en, 8'h00, 8'h00});
    // conditions gone and settled through the synchroniser before clearing
    ls_oc <= 8'h00;
    ol_hs <= 8'h00;
    ol_ls <= 8'h00;
    step(2);
    u_mcu.clear(8'h40, 8'hFF);
    step(2);
    want({1'b1, 8'h00, 8'h00, hs_en, ls_en});
    step(2);
    conclude();
  end
endmodule // tb_half_bridge_fault_manager
